// File: nvwc_chk_assertions.sv
`timescale 1ns/10ps
`default_nettype none

module nvwc_chk #(
  parameter int unsigned OP_CYCLES = 80000
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic abort_rst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic tbl_wr_low_i,
  input wire logic tbl_wr_high_i,
  input wire logic tbl_rd_low_i,
  input wire logic tbl_rd_high_i,
  input wire logic [23:0] tbl_addr_i,
  input wire logic [15:0] tbl_wdata_i,
  input wire logic [15:0] tbl_rdata_o,
  input wire logic cmpl_flag_clr_i,
  input wire logic cmpl_flag_o,
  input wire logic cpu_stall_o
);
  logic [1:0] key_q;
  logic [19:0] cnt_q;
  wire logic acc_w = reg_wr_i | reg_rd_i | tbl_wr_low_i | tbl_wr_high_i | tbl_rd_low_i
    | tbl_rd_high_i;
  wire logic key_w = reg_wr_i && reg_addr_i == 16'h0766;

  // Unlock progress as seen at the pins; any other access drops it
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      key_q <= 2'd0;
    end else if (acc_w) begin
      key_q <= (key_w && reg_wdata_i[7:0] == 8'h55) ? 2'd1 :
        (key_w && reg_wdata_i[7:0] == 8'haa && key_q == 2'd1) ? 2'd2 : 2'd0;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 20'h00000;
    end else begin
      cnt_q <= cpu_stall_o ? cnt_q + 20'h00001 : 20'h00000;
    end
  end

  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  AST_KEY_RD: assert property (reg_rd_i && reg_addr_i == 16'h0766 |=> reg_rdata_o == 16'h0000)
    else $error("key register read back nonzero");
  AST_START_KEY: assert property ($rose(cpu_stall_o) |-> $past(key_q == 2'd2 && reg_wr_i))
    else $error("operation started without unlock");
  AST_EE_NO_STALL: assert property ($rose(cpu_stall_o) |-> !$past(reg_wdata_i[2]))
    else $error("eeprom operation stalled the core");
  AST_STALL_LEN: assert property (cpu_stall_o |-> cnt_q <= OP_CYCLES + 1)
    else $error("stall too long");
  AST_STALL_END: assert property ($fell(cpu_stall_o) && !$past(abort_rst_i) |->
    $past(cnt_q) + 2 >= OP_CYCLES) else $error("stall too short");
  AST_FLAG_SET: assert property ($fell(cpu_stall_o) && !$past(abort_rst_i) |->
    ##[0:2] cmpl_flag_o) else $error("no completion flag");
  AST_FLAG_HOLD: assert property (cmpl_flag_o && !cmpl_flag_clr_i |=> cmpl_flag_o)
    else $error("completion flag lost");
  AST_ABORT: assert property (abort_rst_i |=> !cpu_stall_o)
    else $error("stall survived abort");
  AST_TBL_HOLD: assert property (!(tbl_rd_low_i || tbl_rd_high_i) |=> $stable(tbl_rdata_o))
    else $error("table data changed without read");
  AST_HI_RD: assert property (reg_rd_i && reg_addr_i == 16'h0764 |=> !(|reg_rdata_o[15:8]))
    else $error("high address upper byte nonzero");

  cover property ($rose(cmpl_flag_o));
  cover property ($rose(cpu_stall_o));
  cover property (abort_rst_i ##[1:3] reg_rd_i);
endmodule // nvwc_chk

`default_nettype wire

// File: nvwc_cpu_bfm.sv
`timescale 1ns/10ps
`default_nettype none

module nvwc_cpu_bfm (
  input wire logic mclk_i,
  input wire logic flag_i,
  output logic [6:0] stb_o,
  output logic [23:0] addr_o,
  output logic [15:0] data_o
);
  initial begin
    stb_o = 7'h00;
    addr_o = 24'h000000;
    data_o = 16'h0000;
  end

  // Strobe order: reg wr, reg rd, tbl wr lo, tbl wr hi, tbl rd lo, tbl rd hi, flag clr
  task automatic acc(input int s, input logic [23:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    stb_o <= 7'h01 << s;
    addr_o <= a;
    data_o <= d;
    @(posedge mclk_i);
    stb_o <= 7'h00;
    // Released lines scramble so stale values are never trusted
    addr_o <= ~a;
    data_o <= ~d;
  endtask

  // No interrupt can split the sequence in this model
  task automatic start(input logic [15:0] c);
    acc(0, 24'h000766, 16'h0055);
    acc(0, 24'h000766, 16'h00aa);
    acc(0, 24'h000760, c | 16'h8000);
    repeat (2) @(posedge mclk_i);
  endtask

  // Waits on the flag, never a fixed time
  task automatic wait_done(output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 300 && !ok; i++) begin
      @(posedge mclk_i);
      ok = (flag_i === 1'b1);
    end
    if (ok) acc(6, 24'h000000, 16'h0000);
  endtask
endmodule // nvwc_cpu_bfm

`default_nettype wire

// File: nvwc_defines.svh
`ifndef NVWC_DEFINES_SVH
`define NVWC_DEFINES_SVH

// Register map
`define NVWC_ADDR_CTRL 16'h0760
`define NVWC_ADDR_LO 16'h0762
`define NVWC_ADDR_HI 16'h0764
`define NVWC_ADDR_KEY 16'h0766
`define NVWC_CTRL_RESET 16'h0000
`define NVWC_ADDR_RESET 16'h0000
`define NVWC_KEY_RESET 8'h00

// Control register fields
`define NVWC_BIT_WR 15
`define NVWC_BIT_WRITE_ENABLE_BIT 14
`define NVWC_BIT_WRITE_ERROR_BIT 13
`define NVWC_BIT_TERMINATED_WRITE_FLAG 8
`define NVWC_OP_MSB 6
`define NVWC_OP_W 7
`define NVWC_OP_ERASE 6
`define NVWC_OP_EEPROM 2
`define NVWC_OP_BLOCK 0
`define NVWC_HI_W 8

// Unlock pattern
`define NVWC_KEY_FIRST 8'h55
`define NVWC_KEY_SECOND 8'haa

// Data EEPROM window 0x7ff000..0x7ffffe
`define NVWC_EE_PAGE 12'h7ff
`define NVWC_EE_WORDS 2048
`define NVWC_EE_IDX_W 11
`define NVWC_EE_BLOCK 16
`define NVWC_PLAT_WORDS 32
`define NVWC_ERASED_WORD 16'hffff

// Operation time
`define NVWC_OP_TIME_NS 2000000
`define NVWC_CLK_PERIOD_NS 25
`define NVWC_OP_CYCLES (`NVWC_OP_TIME_NS / `NVWC_CLK_PERIOD_NS)
`define NVWC_TMR_W 20

`endif

// File: nvwc_eng_if.sv
`timescale 1ns/10ps
`default_nettype none
`include "nvwc_defines.svh"

interface nvwc_eng_if;
  logic start;
  logic abort;
  logic [`NVWC_OP_W-1:0] op;
  logic [23:0] addr;
  logic lat_lo;
  logic lat_hi;
  logic [23:0] lat_addr;
  logic [15:0] lat_data;
  logic rd_hi;
  logic [23:0] rd_addr;
  logic [15:0] rd_data;
  logic busy;
  logic done;

  modport ctl (
    output start, abort, op, addr, lat_lo, lat_hi, lat_addr, lat_data, rd_hi, rd_addr,
    input rd_data, busy, done
  );
  modport eng (
    input start, abort, op, addr, lat_lo, lat_hi, lat_addr, lat_data, rd_hi, rd_addr,
    output rd_data, busy, done
  );
endinterface

`default_nettype wire

// File: nvwc_engine.sv
`timescale 1ns/10ps
`default_nettype none
`include "nvwc_defines.svh"

module nvwc_engine #(
  parameter int unsigned OP_CYCLES = `NVWC_OP_CYCLES
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  nvwc_eng_if.eng bus
);

  logic [15:0] ee_mem [0:`NVWC_EE_WORDS-1];
  logic [15:0] dlat [0:`NVWC_EE_BLOCK-1];
  logic [23:0] plat [0:`NVWC_PLAT_WORDS-1];
  nvwc_pkg::nvwc_eng_t state_q;
  logic [`NVWC_TMR_W-1:0] cnt_q;
  logic [`NVWC_OP_W-1:0] op_q;
  logic [`NVWC_EE_IDX_W-1:0] idx_q;
  logic ee_q;
  logic done_q;
  logic commit;

  assign commit = (state_q == nvwc_pkg::ENG_RUN) && !bus.abort && (cnt_q == '0);
  assign bus.busy = (state_q == nvwc_pkg::ENG_RUN);
  assign bus.done = done_q;

  ////////////////////////////////////////////////////////////////////////////
  // Operation timer; runs without holding the core for data EEPROM
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= nvwc_pkg::ENG_IDLE;
      cnt_q <= '0;
      op_q <= '0;
      idx_q <= '0;
      ee_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= commit;
      case (state_q)
        nvwc_pkg::ENG_IDLE: begin
          if (bus.start && !bus.abort) begin
            state_q <= nvwc_pkg::ENG_RUN;
            cnt_q <= `NVWC_TMR_W'(OP_CYCLES - 1);
            op_q <= bus.op;
            idx_q <= bus.addr[`NVWC_EE_IDX_W:1];
            ee_q <= nvwc_pkg::nvwc_is_ee(bus.addr) && bus.op[`NVWC_OP_EEPROM];
          end
        end
        nvwc_pkg::ENG_RUN: begin
          if (bus.abort || cnt_q == '0) begin
            state_q <= nvwc_pkg::ENG_IDLE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        default: begin
          state_q <= nvwc_pkg::ENG_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cell update at the end of the timed operation; aborted ones leave cells alone
  always_ff @(posedge mclk_i) begin
    if (commit && ee_q) begin
      for (int i = 0; i < `NVWC_EE_BLOCK; i++) begin
        if (op_q[`NVWC_OP_BLOCK] || idx_q[3:0] == 4'(i)) begin
          if (op_q[`NVWC_OP_ERASE]) begin
            ee_mem[{idx_q[`NVWC_EE_IDX_W-1:4], 4'(i)}] <= `NVWC_ERASED_WORD;
          end else begin
            ee_mem[{idx_q[`NVWC_EE_IDX_W-1:4], 4'(i)}] <= dlat[i];
          end
        end
      end
    end
  end

  // Write latches: data EEPROM latches are 16 bits, program latches 24
  always_ff @(posedge mclk_i) begin
    if (bus.lat_lo) begin
      if (nvwc_pkg::nvwc_is_ee(bus.lat_addr)) begin
        dlat[bus.lat_addr[4:1]] <= bus.lat_data;
      end else begin
        plat[bus.lat_addr[5:1]][15:0] <= bus.lat_data;
      end
    end
    if (bus.lat_hi && !nvwc_pkg::nvwc_is_ee(bus.lat_addr)) begin
      plat[bus.lat_addr[5:1]][23:16] <= bus.lat_data[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reads during a running operation see the old cell: undefined by contract
  always_comb begin
    bus.rd_data = 16'h0000;
    if (nvwc_pkg::nvwc_is_ee(bus.rd_addr)) begin
      if (!bus.rd_hi) begin
        bus.rd_data = ee_mem[bus.rd_addr[`NVWC_EE_IDX_W:1]];
      end
    end else if (bus.rd_hi) begin
      bus.rd_data = {8'h00, plat[bus.rd_addr[5:1]][23:16]};
    end else begin
      bus.rd_data = plat[bus.rd_addr[5:1]][15:0];
    end
  end

endmodule // nvwc_engine

`default_nettype wire

// File: nvwc_pkg.sv
`include "nvwc_defines.svh"

package nvwc_pkg;

  typedef enum logic [1:0] {
    KEY_IDLE = 2'b00,
    KEY_GOT_FIRST = 2'b01,
    KEY_ARMED = 2'b10
  } nvwc_key_t;

  typedef enum logic [0:0] {
    ENG_IDLE = 1'b0,
    ENG_RUN = 1'b1
  } nvwc_eng_t;

  function automatic logic nvwc_is_ee(input logic [23:0] a);
    return a[23:12] == `NVWC_EE_PAGE;
  endfunction

endpackage

// File: nvwc_top.sv
// How it works
// - Start needs keys 0x55 then 0xaa first
// - Low table write fills latch low word
// - High table write keeps only low byte
// - Data EEPROM at 0x7ff000 to 0x7ffffe
// - EEPROM ops on one word or 16-block
// - Operation address from both address registers
// - Completion signalled by status, not fixed count
// - EEPROM operations never stall the core
// - EEPROM read during operation is undefined
// - Start bit set-only, hardware clears it
// - Writes need write enable, clear at power-up
// - Aborting reset during an operation sets sticky error bit
// - Address registers survive aborting reset
// - Completion flag set by hardware, software clears
// - Low table read returns EEPROM word
// - Block erase uses code 0x4045 then start
// - Flash operations stall core, start self-clears
// - Start ignored unless enable set earlier
// - Low address captures last table address
`timescale 1ns/10ps
`default_nettype none
`include "nvwc_defines.svh"

module nvwc_top #(
  parameter int unsigned OP_CYCLES = `NVWC_OP_CYCLES
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic abort_rst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  input wire logic tbl_wr_low_i,
  input wire logic tbl_wr_high_i,
  input wire logic tbl_rd_low_i,
  input wire logic tbl_rd_high_i,
  input wire logic [23:0] tbl_addr_i,
  input wire logic [15:0] tbl_wdata_i,
  output logic [15:0] tbl_rdata_o,
  input wire logic cmpl_flag_clr_i,
  output logic cmpl_flag_o,
  output logic cpu_stall_o
);

  nvwc_eng_if eng_bus ();

  nvwc_pkg::nvwc_key_t key_q;
  logic wr_q;
  logic write_enable_bit_q;
  logic write_error_bit_q;
  logic terminated_write_flag_q;
  logic [`NVWC_OP_W-1:0] op_q;
  logic [15:0] adr_lo_q;
  logic [`NVWC_HI_W-1:0] adr_hi_q;
  logic [15:0] reg_rdata_q;
  logic [15:0] tbl_rdata_q;
  logic cmpl_q;
  logic stall_q;

  logic tbl_any;
  logic any_access;
  logic ctrl_wr;
  logic key_wr;
  logic lo_wr;
  logic hi_wr;
  logic tbl_rd;
  logic key_armed;
  logic flash_op;
  logic start;
  logic aborted;
  logic [15:0] ctrl_view;

  // Offsets are matched for reads and writes alike
  function automatic logic reg_hit(input logic [15:0] a, input logic [15:0] off);
    return a == off;
  endfunction

  // Only the low byte of a key write counts
  function automatic logic key_is(input logic [15:0] d, input logic [7:0] k);
    return d[7:0] == k;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Access decode
  assign tbl_any = tbl_wr_low_i | tbl_wr_high_i | tbl_rd_low_i | tbl_rd_high_i;
  assign any_access = reg_wr_i | reg_rd_i | tbl_any;
  assign ctrl_wr = reg_wr_i && reg_hit(reg_addr_i, `NVWC_ADDR_CTRL);
  assign key_wr = reg_wr_i && reg_hit(reg_addr_i, `NVWC_ADDR_KEY);
  assign lo_wr = reg_wr_i && reg_hit(reg_addr_i, `NVWC_ADDR_LO);
  assign hi_wr = reg_wr_i && reg_hit(reg_addr_i, `NVWC_ADDR_HI);
  assign tbl_rd = tbl_rd_low_i | tbl_rd_high_i;
  assign aborted = abort_rst_i && eng_bus.busy;
  assign key_armed = (key_q == nvwc_pkg::KEY_ARMED);
  // Data EEPROM work runs in the background; only flash holds the core
  assign flash_op = !reg_wdata_i[`NVWC_OP_EEPROM];

  // Old enable, not the value being written, gates the start
  assign start = ctrl_wr && reg_wdata_i[`NVWC_BIT_WR] && key_armed
    && write_enable_bit_q && !wr_q && !abort_rst_i;

  ////////////////////////////////////////////////////////////////////////////
  // Unlock sequence
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      key_q <= nvwc_pkg::KEY_IDLE;
    end else if (abort_rst_i) begin
      key_q <= nvwc_pkg::KEY_IDLE;
    end else begin
      case (key_q)
        nvwc_pkg::KEY_IDLE: begin
          if (key_wr && key_is(reg_wdata_i, `NVWC_KEY_FIRST)) begin
            key_q <= nvwc_pkg::KEY_GOT_FIRST;
          end
        end
        nvwc_pkg::KEY_GOT_FIRST: begin
          if (key_wr && key_is(reg_wdata_i, `NVWC_KEY_SECOND)) begin
            key_q <= nvwc_pkg::KEY_ARMED;
          end else if (key_wr && key_is(reg_wdata_i, `NVWC_KEY_FIRST)) begin
            key_q <= nvwc_pkg::KEY_GOT_FIRST;
          end else if (any_access) begin
            key_q <= nvwc_pkg::KEY_IDLE;
          end
        end
        nvwc_pkg::KEY_ARMED: begin
          // One shot: the start attempt itself also disarms
          if (any_access) begin
            key_q <= nvwc_pkg::KEY_IDLE;
          end
        end
        default: begin
          key_q <= nvwc_pkg::KEY_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_q <= 1'b0;
    end else if (abort_rst_i) begin
      wr_q <= 1'b0;
    end else if (start) begin
      wr_q <= 1'b1;
    end else if (eng_bus.done) begin
      wr_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      write_enable_bit_q <= 1'b0;
    end else if (abort_rst_i) begin
      write_enable_bit_q <= 1'b0;
    end else if (ctrl_wr) begin
      // Engine latched its op at start, so this never disturbs it
      write_enable_bit_q <= reg_wdata_i[`NVWC_BIT_WRITE_ENABLE_BIT];
    end
  end

  // Error bits: power-on clears them, a software write loads the written bit; abort wins over a software write
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      write_error_bit_q <= 1'b0;
    end else if (aborted) begin
      write_error_bit_q <= 1'b1;
    end else if (ctrl_wr) begin
      write_error_bit_q <= reg_wdata_i[`NVWC_BIT_WRITE_ERROR_BIT];
    end
  end

  // Terminated-write marker follows the error bit on an abort
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      terminated_write_flag_q <= 1'b0;
    end else if (aborted) begin
      terminated_write_flag_q <= 1'b1;
    end else if (ctrl_wr) begin
      terminated_write_flag_q <= reg_wdata_i[`NVWC_BIT_TERMINATED_WRITE_FLAG];
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      op_q <= '0;
    end else if (abort_rst_i) begin
      op_q <= '0;
    end else if (ctrl_wr) begin
      op_q <= reg_wdata_i[`NVWC_OP_MSB:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address registers; an aborting reset leaves them for a retry
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      adr_lo_q <= `NVWC_ADDR_RESET;
    end else if (!abort_rst_i) begin
      if (tbl_any) begin
        adr_lo_q <= tbl_addr_i[15:0];
      end else if (lo_wr) begin
        adr_lo_q <= reg_wdata_i;
      end
    end
  end

  // Table access beats a direct write in the same cycle
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      adr_hi_q <= '0;
    end else if (!abort_rst_i) begin
      if (tbl_any) begin
        adr_hi_q <= tbl_addr_i[23:16];
      end else if (hi_wr) begin
        adr_hi_q <= reg_wdata_i[`NVWC_HI_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Completion flag and core stall
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cmpl_q <= 1'b0;
    end else if (eng_bus.done) begin
      cmpl_q <= 1'b1;
    end else if (cmpl_flag_clr_i) begin
      cmpl_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      stall_q <= 1'b0;
    end else if (abort_rst_i || eng_bus.done) begin
      stall_q <= 1'b0;
    end else if (start && flash_op) begin
      stall_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Unused control bits read as zero
  assign ctrl_view = {wr_q, write_enable_bit_q, write_error_bit_q, 4'h0, terminated_write_flag_q, 1'b0, op_q};

  // Read data, one cycle after the request
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_q <= 16'h0000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `NVWC_ADDR_CTRL: reg_rdata_q <= ctrl_view;
        `NVWC_ADDR_LO: reg_rdata_q <= adr_lo_q;
        `NVWC_ADDR_HI: reg_rdata_q <= {8'h00, adr_hi_q};
        default: reg_rdata_q <= 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tbl_rdata_q <= 16'h0000;
    end else if (tbl_rd) begin
      tbl_rdata_q <= eng_bus.rd_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Engine hookup
  assign eng_bus.start = start;
  assign eng_bus.abort = abort_rst_i;
  assign eng_bus.op = reg_wdata_i[`NVWC_OP_MSB:0];
  assign eng_bus.addr = {adr_hi_q, adr_lo_q};
  assign eng_bus.lat_lo = tbl_wr_low_i;
  assign eng_bus.lat_hi = tbl_wr_high_i;
  assign eng_bus.lat_addr = tbl_addr_i;
  assign eng_bus.lat_data = tbl_wdata_i;
  assign eng_bus.rd_hi = tbl_rd_high_i;
  assign eng_bus.rd_addr = tbl_addr_i;

  nvwc_engine #(
    .OP_CYCLES(OP_CYCLES)
  ) u_engine (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .bus(eng_bus.eng)
  );

  assign reg_rdata_o = reg_rdata_q;
  assign tbl_rdata_o = tbl_rdata_q;
  assign cmpl_flag_o = cmpl_q;
  assign cpu_stall_o = stall_q;

endmodule // nvwc_top

`default_nettype wire

// File: tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb;
  localparam int unsigned OP_CYCLES = 20;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic abort_rst_i = 1'b0;
  logic rr_q = 1'b0;
  logic rt_q = 1'b0;
  logic ok;
  logic cmpl_flag_o, cpu_stall_o;
  logic [6:0] stb;
  logic [23:0] ad;
  logic [15:0] dt, d, reg_rdata_o, tbl_rdata_o;
  logic [15:0] expq[$];
  int error_cnt = 0;
  int n_tests = 0;

  always #12.5 mclk_i = ~mclk_i;

  nvwc_cpu_bfm cpu_u (.mclk_i(mclk_i), .flag_i(cmpl_flag_o), .stb_o(stb), .addr_o(ad),
    .data_o(dt));
  nvwc_top #(.OP_CYCLES(OP_CYCLES)) dut_u (.mclk_i(mclk_i), .rst_i(rst_i),
    .abort_rst_i(abort_rst_i), .reg_wr_i(stb[0]), .reg_rd_i(stb[1]),
    .reg_addr_i(ad[15:0]), .reg_wdata_i(dt), .reg_rdata_o(reg_rdata_o),
    .tbl_wr_low_i(stb[2]), .tbl_wr_high_i(stb[3]), .tbl_rd_low_i(stb[4]),
    .tbl_rd_high_i(stb[5]), .tbl_addr_i(ad), .tbl_wdata_i(dt), .tbl_rdata_o(tbl_rdata_o),
    .cmpl_flag_clr_i(stb[6]), .cmpl_flag_o(cmpl_flag_o), .cpu_stall_o(cpu_stall_o));

  ////////////////////////////////////////////////////////////
  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    chk16({15'h0000, g}, {15'h0000, e});
  endtask

  task automatic rd(input int s, input logic [23:0] a, input logic [15:0] e);
    expq.push_back(e);
    cpu_u.acc(s, a, 16'h0000);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Read data lands one cycle after the strobe
  always @(posedge mclk_i) begin
    rr_q <= stb[1];
    rt_q <= stb[4] | stb[5];
  end

  always @(negedge mclk_i) begin
    if ((rr_q | rt_q) && expq.size() > 0) begin
      chk16(rr_q ? reg_rdata_o : tbl_rdata_o, expq.pop_front());
    end
  end

  initial begin
    #(25 * 20000);
    error_cnt++;
    conclude();
  end

  ////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(76));
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(1, 24'h000760, 16'h0000);
    rd(1, 24'h000766, 16'h0000);
    rd(1, 24'h000768, 16'h0000);
    cpu_u.acc(0, 24'h000760, 16'h0004);
    cpu_u.start(16'h0004);
    rd(1, 24'h000760, 16'h0004);
    cpu_u.start(16'h4004);
    rd(1, 24'h000760, 16'h4004);
    for (int i = 0; i < 2; i++) begin
      cpu_u.acc(0, 24'h000766, 16'h0055);
      if (i == 0) rd(1, 24'h000762, 16'h0000);
      cpu_u.acc(0, 24'h000766, i ? 16'h0056 : 16'h00aa);
      cpu_u.acc(0, 24'h000760, 16'hc004);
      rd(1, 24'h000760, 16'h4004);
    end
    // Erase the block first so the word program starts from blank cells
    cpu_u.acc(0, 24'h000762, 16'hf000);
    cpu_u.acc(0, 24'h000764, 16'h007f);
    cpu_u.acc(0, 24'h000760, 16'h4045);
    cpu_u.start(16'h4045);
    cpu_u.wait_done(ok);
    chk1(ok, 1'b1);
    rd(4, 24'h7ff010, 16'hffff);
    rd(4, 24'h7ff01e, 16'hffff);
    d = 16'($urandom);
    cpu_u.acc(2, 24'h7ff010, d);
    rd(1, 24'h000762, 16'hf010);
    rd(1, 24'h000764, 16'h007f);
    cpu_u.acc(3, 24'h000020, {~d[7:0], d[7:0]});
    rd(5, 24'h000020, {8'h00, d[7:0]});
    cpu_u.acc(0, 24'h000762, 16'hf010);
    cpu_u.acc(0, 24'h000764, 16'h007f);
    cpu_u.acc(0, 24'h000760, 16'h4004);
    cpu_u.start(16'h4004);
    rd(1, 24'h000760, 16'hc004);
    cpu_u.acc(0, 24'h000760, 16'h0004);
    rd(1, 24'h000760, 16'h8004);
    chk1(cpu_stall_o, 1'b0);
    cpu_u.wait_done(ok);
    chk1(ok, 1'b1);
    @(negedge mclk_i);
    chk1(cmpl_flag_o, 1'b0);
    rd(1, 24'h000760, 16'h0004);
    rd(4, 24'h7ff010, d);
    cpu_u.acc(0, 24'h000760, 16'h4044);
    cpu_u.start(16'h4044);
    cpu_u.wait_done(ok);
    chk1(ok, 1'b1);
    rd(4, 24'h7ff012, 16'hffff);
    rd(4, 24'h7ff010, 16'hffff);
    for (int i = 0; i < 2; i++) begin
      cpu_u.acc(0, 24'h000760, i ? 16'h4041 : 16'h4001);
      cpu_u.start(i ? 16'h4041 : 16'h4001);
      chk1(cpu_stall_o, 1'b1);
      cpu_u.wait_done(ok);
      chk1(ok & ~cpu_stall_o, 1'b1);
    end
    cpu_u.acc(2, 24'h7ff040, d);
    cpu_u.acc(0, 24'h000760, 16'h4004);
    cpu_u.start(16'h4004);
    abort_rst_i <= 1'b1;
    @(posedge mclk_i);
    abort_rst_i <= 1'b0;
    rd(1, 24'h000760, 16'h2100);
    rd(1, 24'h000762, 16'hf040);
    rd(1, 24'h000764, 16'h007f);
    repeat (2) @(posedge mclk_i);
    conclude();
  end
endmodule // tb

bind nvwc_top nvwc_chk #(.OP_CYCLES(OP_CYCLES)) chk_u (.mclk_i(mclk_i), .rst_i(rst_i),
  .abort_rst_i(abort_rst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .tbl_wr_low_i(tbl_wr_low_i), .tbl_wr_high_i(tbl_wr_high_i), .tbl_rd_low_i(tbl_rd_low_i),
  .tbl_rd_high_i(tbl_rd_high_i), .tbl_addr_i(tbl_addr_i), .tbl_wdata_i(tbl_wdata_i),
  .tbl_rdata_o(tbl_rdata_o), .cmpl_flag_clr_i(cmpl_flag_clr_i), .cmpl_flag_o(cmpl_flag_o),
  .cpu_stall_o(cpu_stall_o));

`default_nettype wire
